// [logic/lock_pkg.sv]
package lock_pkg;
	// Keypad inputs, one bit per key
	typedef struct packed {
		logic fn;
		logic up;
		logic down;
		logic left;
		logic right;
		logic enter;
	} key_t;

	// What the display is asked to show
	typedef enum logic [2:0] {
		IND_STATUS = 3'h0,
		IND_FUNC = 3'h1,
		IND_VALUE = 3'h2,
		IND_PASS = 3'h3,
		IND_END = 3'h4,
		IND_ERR = 3'h5,
		IND_PARAM = 3'h6
	} ind_t;

	typedef struct packed {
		ind_t ind;
		logic [15:0] digits;
		logic [1:0] cursor;
	} display_t;

	// Keypad dialogue states, Gray coded along the usual path
	typedef enum logic [2:0] {
		ST_STATUS = 3'h0,
		ST_SELECT = 3'h1,
		ST_VIEW = 3'h3,
		ST_ENTRY = 3'h2,
		ST_FLASH = 3'h6,
		ST_PARAM = 3'h7
	} state_t;

	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int NS_PER_MS = 1000000;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int UNLOCK_WINDOW_MIN = 5;
	localparam int WINDOW_TICKS = UNLOCK_WINDOW_MIN * 60 * (NS_PER_MS / TICK_PERIOD_NS) * 1000;
	localparam int FLASH_MS = 500;
	localparam int FLASH_TICKS = FLASH_MS * (NS_PER_MS / TICK_PERIOD_NS);

	// Function numbers and code values, four BCD digits, and the top cursor position
	localparam logic [15:0] FIRST_FUNC = 16'h0001;
	localparam logic [15:0] LOCK_FUNC = 16'h0070;
	localparam logic [15:0] RESTORE_FUNC = 16'h0071;
	localparam logic [15:0] ENC_OFFSET = 16'h3552;
	localparam logic [15:0] CODE_RESET = 16'h0000;
	localparam logic [1:0] CURSOR_MAX = 2'h2;
endpackage : lock_pkg

// [logic/key_sync.sv]
`timescale 1ns/10ps
// Three-stage synchroniser and press detector for keypad pins
module key_sync #(
	parameter int WIDTH = 6
) (
	input wire logic clk, // System clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic [WIDTH-1:0] raw, // Key pins, high while pressed
	output logic [WIDTH-1:0] press // One-cycle pulse per accepted press
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	logic [WIDTH-1:0] level;
	logic [WIDTH-1:0] next_level;
	logic [WIDTH-1:0] next_press;

	if (WIDTH < 1) begin : g_chk
		$error("key_sync needs at least one key");
	end

	// Filtered level follows only when stages two and three agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_level[i] = (s2[i] == s3[i]) ? s3[i] : level[i];
		end
		next_press = next_level & ~level;
	end

	// Registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			level <= '0;
			press <= '0;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			level <= next_level;
			press <= next_press;
		end
	end
endmodule : key_sync

// [logic/parameter_lock.sv]
`timescale 1ns/10ps
module parameter_lock #(
	parameter int TICK_CYCLES = lock_pkg::TICK_CYCLES,
	parameter int WINDOW_TICKS = lock_pkg::WINDOW_TICKS,
	parameter int FLASH_TICKS = lock_pkg::FLASH_TICKS
) (
	input wire logic clk, // System clock, 20 MHz
	input wire logic arst_n, // Asynchronous reset, active low
	input wire lock_pkg::key_t key_pin, // Raw keypad pins, high while pressed
	input wire logic [15:0] retained_code, // Code held in non-volatile store
	output lock_pkg::display_t disp, // Display request
	output logic [15:0] stored_code, // Active code, to non-volatile store
	output logic code_write, // Pulse: stored_code written from code entry
	output logic lock_active, // High while edits are refused
	output logic edit_accept, // Pulse: parameter edit allowed
	output logic edit_reject, // Pulse: parameter edit refused
	output logic factory_restore // Pulse: restore factory settings
);
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int WW = $clog2(WINDOW_TICKS + 1);
	localparam int FW = $clog2(FLASH_TICKS + 1);

	if (TICK_CYCLES < 1 || WINDOW_TICKS < 2 || FLASH_TICKS < 1) begin : g_chk
		$error("parameter_lock timing parameters out of range");
	end

	// Step one BCD digit of a four-digit value up or down, modulo ten
	function automatic logic [15:0] bump_digit(input logic [15:0] v, input logic [1:0] pos,
		input logic up);
		logic [15:0] r;
		logic [3:0] d;
		r = v;
		d = v[{pos, 2'b00} +: 4];
		if (up) begin
			d = (d == 4'h9) ? 4'h0 : d + 4'h1;
		end else begin
			d = (d == 4'h0) ? 4'h9 : d - 4'h1;
		end
		r[{pos, 2'b00} +: 4] = d;
		return r;
	endfunction : bump_digit

	// Hide a code by adding a fixed offset digit by digit, modulo ten
	function automatic logic [15:0] encode(input logic [15:0] c);
		logic [15:0] r;
		logic [4:0] s;
		r = '0;
		for (int i = 0; i < 4; i++) begin
			s = {1'b0, c[i*4 +: 4]} + {1'b0, lock_pkg::ENC_OFFSET[i*4 +: 4]};
			r[i*4 +: 4] = (s > 5'h09) ? 4'(s - 5'h0a) : s[3:0];
		end
		return r;
	endfunction : encode

	lock_pkg::key_t key;
	logic any_key;
	logic any_arrow;
	logic locked;

	lock_pkg::state_t st, next_st;
	logic [15:0] fn_num, next_fn_num;
	logic [15:0] entry, next_entry;
	logic [1:0] cursor, next_cursor;
	logic [15:0] next_code;
	logic unlocked, next_unlocked;
	logic load_done, next_load_done;
	logic [WW-1:0] win_cnt, next_win_cnt;
	logic [FW-1:0] flash_cnt, next_flash_cnt;
	lock_pkg::ind_t flash_ind, next_flash_ind;
	logic [TW-1:0] tick_cnt, next_tick_cnt;
	logic tick, next_tick;
	logic unlock_now;
	lock_pkg::display_t next_disp;
	logic next_code_write;
	logic next_lock_active;
	logic next_edit_accept;
	logic next_edit_reject;
	logic next_factory_restore;

	key_sync #(
		.WIDTH(6)
	) u_keys (
		.clk(clk),
		.arst_n(arst_n),
		.raw(key_pin),
		.press(key)
	);

	assign any_key = |key;
	assign any_arrow = key.up | key.down | key.left | key.right;
	assign locked = (stored_code != lock_pkg::CODE_RESET) && !unlocked;

	// Time base divider
	always_comb begin
		next_tick = 1'b0;
		next_tick_cnt = tick_cnt + TW'(1);
		if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
			next_tick_cnt = '0;
			next_tick = 1'b1;
		end
	end

	// Keypad dialogue, lock state and inactivity window
	always_comb begin
		next_st = st;
		next_fn_num = fn_num;
		next_entry = entry;
		next_cursor = cursor;
		next_code = stored_code;
		next_unlocked = unlocked;
		next_load_done = load_done;
		next_win_cnt = win_cnt;
		next_flash_cnt = flash_cnt;
		next_flash_ind = flash_ind;
		next_code_write = 1'b0;
		next_edit_accept = 1'b0;
		next_edit_reject = 1'b0;
		next_factory_restore = 1'b0;
		unlock_now = 1'b0;
		case (st)
			lock_pkg::ST_STATUS: begin
				if (key.fn) begin
					next_st = lock_pkg::ST_SELECT;
					next_fn_num = lock_pkg::FIRST_FUNC;
					next_cursor = '0;
				end
			end
			lock_pkg::ST_SELECT: begin
				if (key.fn) begin
					next_st = lock_pkg::ST_STATUS;
				end else if (key.left && cursor < lock_pkg::CURSOR_MAX) begin
					next_cursor = cursor + 2'h1;
				end else if (key.right && cursor != 2'h0) begin
					next_cursor = cursor - 2'h1;
				end else if (key.up || key.down) begin
					// A step that would land on function zero is dropped
					if (bump_digit(fn_num, cursor, key.up) != 16'h0000) begin
						next_fn_num = bump_digit(fn_num, cursor, key.up);
					end
				end else if (key.enter) begin
					next_cursor = '0;
					next_st = (fn_num == lock_pkg::LOCK_FUNC) ? lock_pkg::ST_VIEW :
						lock_pkg::ST_PARAM;
				end
			end
			lock_pkg::ST_VIEW: begin
				if (key.fn) begin
					next_st = lock_pkg::ST_SELECT;
				end else if (any_arrow) begin
					next_entry = 16'h0000;
					next_cursor = '0;
					next_st = lock_pkg::ST_ENTRY;
				end
			end
			lock_pkg::ST_ENTRY: begin
				if (key.fn) begin
					next_st = lock_pkg::ST_SELECT;
				end else if (key.left && cursor < lock_pkg::CURSOR_MAX) begin
					next_cursor = cursor + 2'h1;
				end else if (key.right && cursor != 2'h0) begin
					next_cursor = cursor - 2'h1;
				end else if (key.up || key.down) begin
					next_entry = bump_digit(entry, cursor, key.up);
				end else if (key.enter) begin
					next_st = lock_pkg::ST_FLASH;
					next_flash_cnt = '0;
					next_cursor = '0;
					if (locked) begin
						if (entry == stored_code) begin
							next_unlocked = 1'b1;
							unlock_now = 1'b1;
							next_flash_ind = lock_pkg::IND_PASS;
						end else begin
							next_flash_ind = lock_pkg::IND_ERR;
						end
					end else begin
						next_code = entry;
						next_code_write = 1'b1;
						// A first code from the unlocked-free state locks at once
						if (stored_code == lock_pkg::CODE_RESET) begin
							next_unlocked = 1'b0;
						end
						next_flash_ind = lock_pkg::IND_END;
					end
				end
			end
			lock_pkg::ST_FLASH: begin
				if (tick) begin
					next_flash_cnt = flash_cnt + FW'(1);
					if (flash_cnt == FW'(FLASH_TICKS - 1)) begin
						next_st = lock_pkg::ST_SELECT;
					end
				end
			end
			lock_pkg::ST_PARAM: begin
				if (key.fn) begin
					next_st = lock_pkg::ST_SELECT;
				end else if (key.enter) begin
					next_st = lock_pkg::ST_FLASH;
					next_flash_cnt = '0;
					if (locked) begin
						next_edit_reject = 1'b1;
						next_flash_ind = lock_pkg::IND_ERR;
					end else begin
						next_edit_accept = 1'b1;
						// Restore touches settings only, never the code or lock
						next_factory_restore = (fn_num == lock_pkg::RESTORE_FUNC);
						next_flash_ind = lock_pkg::IND_END;
					end
				end
			end
			default: begin
				next_st = lock_pkg::ST_STATUS;
			end
		endcase
		// Inactivity window
		if (any_key || unlock_now) begin
			next_win_cnt = '0;
		end else if (unlocked && tick) begin
			if (win_cnt == WW'(WINDOW_TICKS - 1)) begin
				next_win_cnt = '0;
				next_unlocked = 1'b0;
			end else begin
				next_win_cnt = win_cnt + WW'(1);
			end
		end
		// First cycle after release picks up the retained code
		if (!load_done) begin
			next_code = retained_code;
			next_unlocked = 1'b0;
			next_load_done = 1'b1;
		end
	end

	// Display and lock flag follow the next state so they match the state registers
	always_comb begin
		next_lock_active = (next_code != lock_pkg::CODE_RESET) && !next_unlocked;
		next_disp.cursor = next_cursor;
		case (next_st)
			lock_pkg::ST_STATUS: begin
				next_disp.ind = lock_pkg::IND_STATUS;
				next_disp.digits = 16'h0000;
			end
			lock_pkg::ST_SELECT: begin
				next_disp.ind = lock_pkg::IND_FUNC;
				next_disp.digits = next_fn_num;
			end
			lock_pkg::ST_VIEW: begin
				next_disp.ind = lock_pkg::IND_VALUE;
				next_disp.digits = encode(next_code);
			end
			lock_pkg::ST_ENTRY: begin
				next_disp.ind = lock_pkg::IND_VALUE;
				next_disp.digits = next_entry;
			end
			lock_pkg::ST_FLASH: begin
				next_disp.ind = next_flash_ind;
				next_disp.digits = next_fn_num;
			end
			lock_pkg::ST_PARAM: begin
				next_disp.ind = lock_pkg::IND_PARAM;
				next_disp.digits = next_fn_num;
			end
			default: begin
				next_disp.ind = lock_pkg::IND_STATUS;
				next_disp.digits = 16'h0000;
			end
		endcase
	end

	// Registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= lock_pkg::ST_STATUS;
			fn_num <= lock_pkg::FIRST_FUNC;
			entry <= 16'h0000;
			cursor <= '0;
			stored_code <= lock_pkg::CODE_RESET;
			unlocked <= 1'b0;
			load_done <= 1'b0;
			win_cnt <= '0;
			flash_cnt <= '0;
			flash_ind <= lock_pkg::IND_END;
			tick_cnt <= '0;
			tick <= 1'b0;
			disp <= '{ind: lock_pkg::IND_STATUS, digits: 16'h0000, cursor: 2'h0};
			code_write <= 1'b0;
			lock_active <= 1'b0;
			edit_accept <= 1'b0;
			edit_reject <= 1'b0;
			factory_restore <= 1'b0;
		end else begin
			st <= next_st;
			fn_num <= next_fn_num;
			entry <= next_entry;
			cursor <= next_cursor;
			stored_code <= next_code;
			unlocked <= next_unlocked;
			load_done <= next_load_done;
			win_cnt <= next_win_cnt;
			flash_cnt <= next_flash_cnt;
			flash_ind <= next_flash_ind;
			tick_cnt <= next_tick_cnt;
			tick <= next_tick;
			disp <= next_disp;
			code_write <= next_code_write;
			lock_active <= next_lock_active;
			edit_accept <= next_edit_accept;
			edit_reject <= next_edit_reject;
			factory_restore <= next_factory_restore;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence confirm_param_locked;
		st == lock_pkg::ST_PARAM && !key.fn && key.enter && locked;
	endsequence
	sequence confirm_code;
		st == lock_pkg::ST_ENTRY && !key.fn && !any_arrow && key.enter && load_done;
	endsequence

	reject_locked_a: assert property (
		confirm_param_locked |=> edit_reject && !edit_accept && disp.ind == lock_pkg::IND_ERR)
		else $error("locked edit not refused");
	good_code_a: assert property (
		confirm_code ##0 (locked && entry == stored_code) |=> !lock_active
		&& disp.ind == lock_pkg::IND_PASS) else $error("right code did not unlock");
	wrong_code_a: assert property (
		confirm_code ##0 (locked && entry != stored_code) |=> lock_active
		&& disp.ind == lock_pkg::IND_ERR && $stable(stored_code))
		else $error("wrong code handled badly");
	new_code_a: assert property (
		confirm_code ##0 !locked |=> code_write && stored_code == $past(entry)
		&& disp.ind == lock_pkg::IND_END) else $error("code not stored");
	zero_off_a: assert property (
		lock_active == (stored_code != 16'h0000 && !unlocked))
		else $error("lock flag disagrees with code");
	encoded_zero_a: assert property (
		st == lock_pkg::ST_VIEW && stored_code == 16'h0000 |-> disp.digits == 16'h3552)
		else $error("zero code not shown as 3552");
	entry_range_a: assert property (
		st == lock_pkg::ST_ENTRY |-> entry[15:12] == 4'h0 && cursor <= 2'h2)
		else $error("code entry out of range");
	restore_keep_a: assert property (
		factory_restore |-> $stable(stored_code) && $stable(lock_active))
		else $error("restore changed the lock");
	fn_nonzero_a: assert property (
		fn_num != 16'h0000) else $error("function zero selected");
	fn_first_a: assert property (
		st == lock_pkg::ST_STATUS && key.fn |=> st == lock_pkg::ST_SELECT
		&& disp.digits == 16'h0001 && disp.ind == lock_pkg::IND_FUNC)
		else $error("function key did not show function one");
	window_clear_a: assert property (
		any_key |=> win_cnt == '0) else $error("key press left window running");
	relock_a: assert property (
		unlocked && tick && !any_key && win_cnt == WW'(WINDOW_TICKS - 1) |=> !unlocked
		##0 lock_active == (stored_code != 16'h0000)) else $error("window did not expire");
	flash_end_a: assert property (
		st == lock_pkg::ST_FLASH && tick && flash_cnt == FW'(FLASH_TICKS - 1)
		|=> st == lock_pkg::ST_SELECT && disp.ind == lock_pkg::IND_FUNC)
		else $error("flash did not return to function number");
	load_a: assert property (
		!load_done |=> stored_code == $past(retained_code) && !unlocked)
		else $error("retained code not taken at start");
endmodule : parameter_lock

// [verif/keypad_operator.sv]
`timescale 1ns/10ps
// Operator at the front keypad, one key at a time
module keypad_operator (
	input wire logic clk, // System clock
	output lock_pkg::key_t key_pin // Key pins, high while pressed
);
	initial key_pin = lock_pkg::key_t'(6'h00);

	// Hold past the synchroniser, then release fully before the next press
	task automatic press(input int k, input int n);
		repeat (n) begin
			@(negedge clk);
			key_pin = lock_pkg::key_t'(6'h01 << k);
			repeat (6) @(negedge clk);
			key_pin = lock_pkg::key_t'(6'h00);
			repeat (3) @(negedge clk);
		end
	endtask : press
endmodule : keypad_operator

// [verif/test_parameter_lock.sv]
`timescale 1ns/10ps
module test_parameter_lock;
	localparam int K_EN = 0;
	localparam int K_RT = 1;
	localparam int K_LF = 2;
	localparam int K_DN = 3;
	localparam int K_UP = 4;
	localparam int K_FN = 5;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [15:0] retained_code = 16'h0000;
	lock_pkg::key_t key_pin;
	lock_pkg::display_t disp;
	logic [15:0] stored_code;
	logic code_write;
	logic lock_active;
	logic edit_accept;
	logic edit_reject;
	logic factory_restore;
	int bad_count = 0;
	int check_count = 0;
	int n_write = 0;
	int n_acc = 0;
	int n_rej = 0;
	int n_rst = 0;

	// Clock, 50 ns period
	always #25 clk = ~clk;

	keypad_operator op (.clk(clk), .key_pin(key_pin));

	parameter_lock #(.TICK_CYCLES(4), .WINDOW_TICKS(20), .FLASH_TICKS(3)) uut (
		.clk(clk),
		.arst_n(arst_n),
		.key_pin(key_pin),
		.retained_code(retained_code),
		.disp(disp),
		.stored_code(stored_code),
		.code_write(code_write),
		.lock_active(lock_active),
		.edit_accept(edit_accept),
		.edit_reject(edit_reject),
		.factory_restore(factory_restore)
	);

	// Tally of one-cycle pulses
	always @(posedge clk) begin
		if (code_write === 1'b1) n_write++;
		if (edit_accept === 1'b1) n_acc++;
		if (edit_reject === 1'b1) n_rej++;
		if (factory_restore === 1'b1) n_rst++;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_disp(input lock_pkg::ind_t ind, input logic [15:0] dig);
		check_count++;
		if ({disp.ind, disp.digits} !== {ind, dig}) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time,
				{disp.ind, disp.digits}, {ind, dig});
		end
	endtask : chk_disp

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle

	task automatic key(input int k, input int n);
		op.press(k, n);
	endtask : key

	task automatic chk_ind(input lock_pkg::ind_t ind);
		chk_val(16'(disp.ind), 16'(ind));
	endtask : chk_ind

	task automatic do_reset(input logic [15:0] code);
		retained_code = code;
		arst_n = 1'b0;
		idle(12);
		arst_n = 1'b1;
		idle(3);
	endtask : do_reset

	// Digit entry in the value view; the extra left at the top digit must be ignored
	task automatic entry(input int c0, input int c1, input int c2);
		key(K_UP, 1);
		chk_disp(lock_pkg::IND_VALUE, 16'h0000);
		key(K_UP, c0);
		key(K_LF, 1);
		key(K_UP, c1);
		key(K_LF, 2);
		chk_val(16'(disp.cursor), 16'h0002);
		key(K_UP, c2);
	endtask : entry

	task automatic t_set_code();
		key(K_FN, 1);
		chk_disp(lock_pkg::IND_FUNC, 16'h0001);
		key(K_DN, 1);
		chk_disp(lock_pkg::IND_FUNC, 16'h0001);
		key(K_LF, 1);
		key(K_UP, 7);
		key(K_RT, 1);
		key(K_DN, 1);
		chk_disp(lock_pkg::IND_FUNC, 16'h0070);
		key(K_EN, 1);
		chk_disp(lock_pkg::IND_VALUE, 16'h3552);
		entry(3, 2, 1);
		chk_disp(lock_pkg::IND_VALUE, 16'h0123);
		key(K_EN, 1);
		chk_ind(lock_pkg::IND_END);
		chk_val(stored_code, 16'h0123);
		chk_val(16'(lock_active), 16'h0001);
		chk_val(16'(n_write), 16'h0001);
		idle(16);
		chk_disp(lock_pkg::IND_FUNC, 16'h0070);
	endtask : t_set_code

	task automatic t_locked_edit();
		key(K_RT, 2);
		key(K_UP, 1);
		chk_disp(lock_pkg::IND_FUNC, 16'h0071);
		key(K_EN, 1);
		chk_ind(lock_pkg::IND_PARAM);
		key(K_EN, 1);
		chk_ind(lock_pkg::IND_ERR);
		chk_val(16'(n_rej), 16'h0001);
		chk_val(16'(n_rst), 16'h0000);
		idle(16);
		key(K_DN, 1);
		chk_disp(lock_pkg::IND_FUNC, 16'h0070);
	endtask : t_locked_edit

	task automatic t_unlock();
		key(K_EN, 1);
		chk_disp(lock_pkg::IND_VALUE, 16'h3675);
		entry(1, 0, 0);
		key(K_EN, 1);
		chk_ind(lock_pkg::IND_ERR);
		chk_val(16'(lock_active), 16'h0001);
		idle(16);
		key(K_EN, 1);
		entry(3, 2, 1);
		key(K_EN, 1);
		chk_ind(lock_pkg::IND_PASS);
		chk_val(16'(lock_active), 16'h0000);
		idle(16);
	endtask : t_unlock

	task automatic t_restore();
		key(K_RT, 2);
		key(K_UP, 1);
		key(K_EN, 2);
		chk_val(16'(n_acc), 16'h0001);
		chk_val(16'(n_rst), 16'h0001);
		chk_val(stored_code, 16'h0123);
		chk_val(16'(lock_active), 16'h0000);
		idle(16);
		key(K_DN, 1);
	endtask : t_restore

	task automatic t_window();
		key(K_LF, 10);
		chk_val(16'(lock_active), 16'h0000);
		idle(110);
		chk_val(16'(lock_active), 16'h0001);
	endtask : t_window

	task automatic t_change();
		key(K_EN, 1);
		entry(3, 2, 1);
		key(K_EN, 1);
		idle(16);
		key(K_EN, 1);
		entry(0, 0, 1);
		chk_disp(lock_pkg::IND_VALUE, 16'h0100);
		key(K_EN, 1);
		chk_val(stored_code, 16'h0100);
		chk_val(16'(lock_active), 16'h0000);
		idle(16);
		key(K_EN, 1);
		chk_disp(lock_pkg::IND_VALUE, 16'h3652);
		entry(0, 0, 0);
		key(K_EN, 1);
		chk_val(stored_code, 16'h0000);
		chk_val(16'(n_write), 16'h0003);
		idle(110);
		chk_val(16'(lock_active), 16'h0000);
	endtask : t_change

	// Function key backs out of view, then out to the status display, and later out of a parameter edit
	task automatic t_escape();
		key(K_EN, 1);
		key(K_FN, 1);
		chk_disp(lock_pkg::IND_FUNC, 16'h0070);
		key(K_FN, 1);
		chk_disp(lock_pkg::IND_STATUS, 16'h0000);
		key(K_FN, 1);
		chk_disp(lock_pkg::IND_FUNC, 16'h0001);
		key(K_EN, 1);
		chk_ind(lock_pkg::IND_PARAM);
		key(K_FN, 1);
		chk_disp(lock_pkg::IND_FUNC, 16'h0001);
	endtask : t_escape

	// Main sequence
	initial begin
		do_reset(16'h0000);
		chk_val(16'(lock_active), 16'h0000);
		chk_disp(lock_pkg::IND_STATUS, 16'h0000);
		t_set_code();
		t_locked_edit();
		t_unlock();
		t_restore();
		t_window();
		t_change();
		t_escape();
		do_reset(16'h0100);
		chk_val(16'(lock_active), 16'h0001);
		chk_val(stored_code, 16'h0100);
		test_done();
	end

	// Watchdog, well beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		test_done();
	end
endmodule : test_parameter_lock
